//--- test/cmp_ref_ctrl_chk.sv
// Assertions for the comparator and reference control block.
// Bound onto cmp_ref_ctrl; sees only its ports, one clock domain.
`timescale 1ns/1ps
module cmp_ref_ctrl_chk
  import cmp_ref_pkg::*;
(
  input  wire logic                           sys_clk,        // Clock
  input  wire logic                           sys_rst,        // Reset
  input  wire logic [cmp_ref_pkg::ADDR_W-1:0] reg_addr,       // Index
  input  wire logic [15:0]                    reg_wdata,      // Write data
  input  wire logic                           reg_wr,         // Write strobe
  input  wire logic                           reg_rd,         // Read strobe
  input  wire logic [15:0]                    reg_rdata,      // Read data
  input  wire logic [2:0]                     unit_active,    // Core enables
  input  wire logic [2:0]                     result_pin,     // Result pins
  input  wire logic [2:0]                     result_pin_oe,  // Drive enables
  input  wire logic [2:0]                     event_pulse,    // Triggers
  input  wire logic                           ladder_power,   // Ladder power
  input  wire logic                           ladder_pin_out, // Ladder to pin
  input  wire logic [5:0]                     ladder_tap,     // Tap code
  input  wire logic                           ladder_range    // Range
);
  // ****************************************************************
  // Register port and event checks
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Access steps; the reference write step serves two checks
  sequence s_ref_wr;
    reg_wr && reg_addr == OFS_REF;
  endsequence
  sequence s_bad_rd;
    reg_rd && reg_addr > OFS_REF;
  endsequence

  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (s_bad_rd |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_tap_code: assert property (s_ref_wr |=> ladder_range == $past(reg_wdata[5]) && ladder_tap ==
    ($past(reg_wdata[5]) ? {2'h0, $past(reg_wdata[3:0])} : 6'h08 + $past(reg_wdata[3:0])))
    else $error("ladder tap wrong");
  chk_ladder_power: assert property (s_ref_wr |=> ladder_power == $past(reg_wdata[7]))
    else $error("ladder power wrong");
  chk_pin_gated: assert property (ladder_pin_out |-> ladder_power)
    else $error("ladder pin without power");
  chk_oe_write: assert property (reg_wr && reg_addr == OFS_CTRL1 |=> result_pin_oe[0] == $past(reg_wdata[14]))
    else $error("pin drive enable wrong");
  chk_pulse_once: assert property (event_pulse[0] |=> !event_pulse[0])
    else $error("second trigger while flag set");
  // A stopped unit must stay silent even if its result drops
  chk_inactive_quiet: assert property ((event_pulse & ~unit_active) == 3'h0)
    else $error("trigger from inactive unit");
  chk_result_off: assert property (!unit_active[1] |-> !result_pin[1])
    else $error("result pin from inactive unit");
endmodule

bind cmp_ref_ctrl cmp_ref_ctrl_chk u_chk (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .unit_active, .result_pin, .result_pin_oe, .event_pulse, .ladder_power, .ladder_pin_out, .ladder_tap, .ladder_range);

//--- test/test_triple_comparator_ref_control.sv
// Self-checking bench for the comparator and reference control block.
// Drives every port itself; the checker file is compiled alongside.
`timescale 1ns/1ps
module test_triple_comparator_ref_control;
  import cmp_ref_pkg::*;
  logic        sys_clk, sys_rst, reg_wr, reg_rd, idle_mode, inv, raw0, r1, flag;
  logic        ladder_power, ladder_pin_out, ladder_source, ladder_range, plus_ref_route;
  logic [2:0]  reg_addr, analog_raw, unit_active, plus_input_select, result_pin, result_pin_oe, event_pulse;
  logic [5:0]  minus_input_select, ladder_tap;
  logic [1:0]  minus_ref_route, code;
  logic [4:0]  lv;
  logic [15:0] reg_wdata, reg_rdata, rd_val, wv, expv;
  int          failures, comparisons, pulses, u;

  cmp_ref_ctrl u_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .idle_mode,
    .analog_raw, .unit_active, .plus_input_select, .minus_input_select, .result_pin, .result_pin_oe, .event_pulse,
    .ladder_power, .ladder_pin_out, .ladder_source, .ladder_tap, .ladder_range, .plus_ref_route, .minus_ref_route);

  // ****************************************************************
  // Clock, pulse counter, watchdog
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Counted on the falling edge so the reset at the rising edge never races
  always @(negedge sys_clk)
    if (event_pulse[u] === 1'b1)
      pulses++;

  initial
  begin
    #5000000;
    failures++;
    summarize();
  end

  // ****************************************************************
  // Register port tasks and comparison
  // ****************************************************************
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task rd(input logic [2:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    {reg_wr, reg_rd, idle_mode, sys_rst} = 4'h1;
    {reg_addr, analog_raw, reg_wdata} = 22'h0;
    u = 0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values; unmapped places stay zero after a write
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a));
      chk("reset", 16'h0000, rd_val);
      if (a > 4)
      begin
        wr(3'(a), 16'hFFFF);
        rd(3'(a));
        chk("unmapped", 16'h0000, rd_val);
      end
    end
    wr(OFS_CTRL1, 16'h1C2C);
    rd(OFS_CTRL1);
    chk("ctrl mask", 16'h0000, rd_val);
    wr(OFS_STAT, 16'h7FFF);
    rd(OFS_STAT);
    chk("stat mask", 16'h0000, rd_val);
    // Every ladder level in both ranges, other reference fields varied
    for (int j = 0; j < 32; j++)
    begin
      lv = 5'(j);
      wv = {5'h00, lv[3], lv[1:0], lv[0], lv[1], lv[4], lv[2], lv[3:0]};
      expv = {3'h0, lv[0], lv[1] & lv[0], lv[2], lv[4], lv[3], lv[1:0], lv[4] ? {2'h0, lv[3:0]} : 6'h08 + lv[3:0]};
      wr(OFS_REF, wv);
      #1;
      chk("ladder", expv, {3'h0, ladder_power, ladder_pin_out, ladder_source, ladder_range, plus_ref_route,
        minus_ref_route, ladder_tap});
      rd(OFS_REF);
      chk("ref rd", wv, rd_val);
    end
    // Input routing and pin drive, units left off
    for (int k = 0; k < 12; k++)
    begin
      u = k % 3;
      code = 2'(k / 3);
      wr(3'(u), {1'b0, code[0], 9'h000, code[1], 2'h0, code});
      #1;
      chk("route", {2'h0, code[1], code[0], code}, {unit_active[u], result_pin[u], plus_input_select[u], result_pin_oe[u], minus_input_select[2*u+:2]});
    end
    // Every edge code, polarity and direction on every unit
    for (int k = 0; k < 48; k++)
    begin
      u = k % 3;
      code = 2'(k / 3);
      inv = 1'(k / 12);
      raw0 = 1'(k / 24);
      r1 = ~(raw0 ^ inv);
      flag = (code == EDGE_ANY) || (code == EDGE_RISE && r1) || (code == EDGE_FALL && !r1);
      analog_raw <= 3'(raw0) << u;
      wr(3'(u), {2'b10, inv, 13'h0000});
      repeat (6) @(posedge sys_clk);
      wr(3'(u), {2'b10, inv, 5'h00, code, 6'h00});
      pulses = 0;
      analog_raw <= 3'(!raw0) << u;
      repeat (6) @(posedge sys_clk);
      chk("pin", 16'(r1), 16'(result_pin[u]));
      rd(3'(u));
      chk("event ctrl", {2'b10, inv, 3'h0, flag, r1, code, 6'h00}, rd_val);
      rd(OFS_STAT);
      chk("event stat", (16'(flag) << (8 + u)) | (16'(r1) << u), rd_val);
      @(posedge sys_clk);
      analog_raw <= 3'(raw0) << u;
      repeat (6) @(posedge sys_clk);
      chk("pulses", 16'(code != EDGE_NONE), 16'(pulses));
      wr(3'(u), {2'b10, inv, 13'h0000});
      rd(OFS_STAT);
      chk("cleared", 16'(raw0 ^ inv) << u, rd_val);
      wr(3'(u), 16'h0000);
    end
    // Idle halt stops an enabled unit only when asked
    analog_raw <= 3'h1;
    wr(OFS_CTRL1, 16'h8000);
    idle_mode <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(OFS_STAT);
    chk("idle run", 16'h0001, rd_val);
    chk("idle act", 16'h0001, 16'(unit_active));
    wr(OFS_STAT, 16'h8000);
    repeat (6) @(posedge sys_clk);
    rd(OFS_STAT);
    chk("idle stop", 16'h8000, rd_val);
    chk("halted", 16'h0000, 16'(unit_active));
    summarize();
  end
endmodule

//--- verilog/cmp_ref_ctrl.sv
// Control for three comparators and their shared programmable reference.
// Assumes a plain register port and analog cores outside this block.
//
// Behaviour
// - Each comparator runs only while enabled
// - Pin drive shows unsynchronised result
// - Polarity bit inverts comparator output
// - Event sets flag, blocks further triggers
// - Code 11 fires on any change
// - Code 10 fires on falling edge
// - Code 01 fires on rising edge
// - Code 00 fires nothing
// - Plus select: reference or pin A
// - Minus select: reference, pins D, C, B
// - Status bits 8-10 copy event flags
// - Status bits 0-2 copy results
// - Idle halt stops all comparators
// - Two ranges of sixteen levels
// - Range sets ladder step and offset
// - Source: reference pins or supply rails
// - Ladder powered only while enabled
// - Pin output connects ladder to pin
// - Plus reference: pin or ladder
// - Minus reference: pin or bandgap taps
// - Unimplemented bits read zero
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps

module cmp_ref_ctrl
  import cmp_ref_pkg::*;
(
  input  wire logic                           sys_clk,   // 10 MHz clock
  input  wire logic                           sys_rst,   // Sync reset, active high
  input  wire logic [cmp_ref_pkg::ADDR_W-1:0] reg_addr,  // Register index
  input  wire logic [15:0]                    reg_wdata, // Write data
  input  wire logic                           reg_wr,    // Write strobe
  input  wire logic                           reg_rd,    // Read strobe
  output logic [15:0]                         reg_rdata, // Read data, next cycle
  input  wire logic                           idle_mode, // Device is in idle
  input  wire logic [2:0]                     analog_raw, // Raw analog results
  output logic [2:0]                          unit_active, // Analog core enables
  output logic [2:0]                          plus_input_select, // 1 = plus ref
  output logic [5:0]                          minus_input_select, // 2 bits per unit
  output logic [2:0]                          result_pin, // Result pins
  output logic [2:0]                          result_pin_oe, // Pin drive enables
  output logic [2:0]                          event_pulse, // Trigger pulses
  output logic                                ladder_power, // Ladder power
  output logic                                ladder_pin_out, // Ladder to pin
  output logic                                ladder_source, // 1 = ref pins
  output logic [5:0]                          ladder_tap, // Ladder tap in 32nds or 24ths
  output logic                                ladder_range, // 1 = 24ths
  output logic                                plus_ref_route, // 1 = ref pin
  output logic [1:0]                          minus_ref_route // Minus ref source
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [15:0] ctrl_r [3];
  logic        idle_halt_all_r;
  logic [15:0] ref_r;
  logic [15:0] rdata_r;
  logic [2:0]  result_bit;
  logic [2:0]  event_flag;
  logic [2:0]  evt_clear;
  logic [15:0] stat_word;
  logic [15:0] rd_mux;
  logic        run_ok;

  // Read view of a control word with live result and flag
  function automatic logic [15:0] ctrl_view(input logic [15:0] w, input logic evt, input logic res);
    logic [15:0] v;
    v         = w & CC_WMASK;
    v[CC_EVT] = evt;
    v[CC_RES] = res;
    return v;
  endfunction

  // ****************************************************************
  // Comparator units
  // ****************************************************************
  assign run_ok = ~(idle_halt_all_r & idle_mode);

  for (genvar i = 0; i < 3; i++)
  begin : g_unit
    // A zero written to the flag bit re-arms the unit
    assign evt_clear[i] = reg_wr & (reg_addr == (OFS_CTRL1 + 3'(i))) & ~reg_wdata[CC_EVT];

    cmp_unit u_unit (
      .sys_clk           (sys_clk),
      .sys_rst           (sys_rst),
      .comparator_on     (ctrl_r[i][CC_ON]),
      .run_ok            (run_ok),
      .result_invert     (ctrl_r[i][CC_INV]),
      .event_edge_select (ctrl_r[i][CC_EDGE_H:CC_EDGE_L]),
      .event_clear       (evt_clear[i]),
      .analog_raw        (analog_raw[i]),
      .result_bit        (result_bit[i]),
      .event_flag        (event_flag[i]),
      .event_pulse       (event_pulse[i]),
      .active            (unit_active[i])
    );

    // Pin path bypasses the sync on purpose, so it may glitch
    assign result_pin[i]    = (analog_raw[i] ^ ctrl_r[i][CC_INV]) & unit_active[i];
    assign result_pin_oe[i] = ctrl_r[i][CC_PIN];
    assign plus_input_select[i] = ctrl_r[i][CC_PLUS];
    assign minus_input_select[2*i+1 -: 2] = ctrl_r[i][CC_MIN_H:CC_MIN_L];
  end

  // ****************************************************************
  // Reference outputs
  // ****************************************************************
  assign ladder_power    = ref_r[RC_POWER];
  assign ladder_pin_out  = ref_r[RC_PIN] & ref_r[RC_POWER];
  assign ladder_source   = ref_r[RC_SOURCE];
  assign ladder_range    = ref_r[RC_RANGE];
  // Range one taps level/24; range zero adds a quarter-span offset
  assign ladder_tap      = ref_r[RC_RANGE] ? {2'h0, ref_r[RC_LVL_H:RC_LVL_L]} :
                           LADDER_LO_BASE + {2'h0, ref_r[RC_LVL_H:RC_LVL_L]};
  assign plus_ref_route  = ref_r[RC_PLUS];
  assign minus_ref_route = ref_r[RC_MIN_H:RC_MIN_L];

  // ****************************************************************
  // Read decode
  // ****************************************************************
  assign stat_word = {idle_halt_all_r, 4'h0, event_flag, 5'h00, result_bit};
  assign rd_mux = (reg_addr == OFS_CTRL1) ? ctrl_view(ctrl_r[0], event_flag[0], result_bit[0]) :
                  (reg_addr == OFS_CTRL2) ? ctrl_view(ctrl_r[1], event_flag[1], result_bit[1]) :
                  (reg_addr == OFS_CTRL3) ? ctrl_view(ctrl_r[2], event_flag[2], result_bit[2]) :
                  (reg_addr == OFS_STAT)  ? stat_word :
                  (reg_addr == OFS_REF)   ? (ref_r & RC_WMASK) : 16'h0000;
  assign reg_rdata = rdata_r;

  // Control words; flag and result bits live in the units
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_r[0] <= RST_CTRL;
      ctrl_r[1] <= RST_CTRL;
      ctrl_r[2] <= RST_CTRL;
    end
    else if (reg_wr && reg_addr <= OFS_CTRL3)
    begin
      ctrl_r[reg_addr[1:0]] <= reg_wdata & CC_WMASK;
    end
  end

  // Status and reference words
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      idle_halt_all_r <= RST_STAT[ST_IDLE];
      ref_r           <= RST_REF;
    end
    else
    begin
      if (reg_wr && reg_addr == OFS_STAT)
        idle_halt_all_r <= reg_wdata[ST_IDLE];
      if (reg_wr && reg_addr == OFS_REF)
        ref_r <= reg_wdata & RC_WMASK;
    end
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
  end

endmodule

//--- verilog/cmp_ref_pkg.sv
// Package for the triple comparator and reference control block.
// Assumes a 16-bit register port with read data one cycle after the strobe.
package cmp_ref_pkg;

  // ****************************************************************
  // Register offsets (word index on the plain register port)
  // ****************************************************************
  localparam logic [2:0] OFS_CTRL1 = 3'h0;
  localparam logic [2:0] OFS_CTRL2 = 3'h1;
  localparam logic [2:0] OFS_CTRL3 = 3'h2;
  localparam logic [2:0] OFS_STAT  = 3'h3;
  localparam logic [2:0] OFS_REF   = 3'h4;
  localparam int         ADDR_W    = 3;

  // ****************************************************************
  // Comparator control field positions
  // ****************************************************************
  localparam int CC_ON     = 15;
  localparam int CC_PIN    = 14;
  localparam int CC_INV    = 13;
  localparam int CC_EVT    = 9;
  localparam int CC_RES    = 8;
  localparam int CC_EDGE_H = 7;
  localparam int CC_EDGE_L = 6;
  localparam int CC_PLUS   = 4;
  localparam int CC_MIN_H  = 1;
  localparam int CC_MIN_L  = 0;
  localparam logic [15:0] CC_WMASK = 16'hE2D3;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int ST_IDLE  = 15;
  localparam int ST_EVT_L = 8;
  localparam int ST_RES_L = 0;

  // ****************************************************************
  // Reference control field positions
  // ****************************************************************
  localparam int RC_PLUS   = 10;
  localparam int RC_MIN_H  = 9;
  localparam int RC_MIN_L  = 8;
  localparam int RC_POWER  = 7;
  localparam int RC_PIN    = 6;
  localparam int RC_RANGE  = 5;
  localparam int RC_SOURCE = 4;
  localparam int RC_LVL_H  = 3;
  localparam int RC_LVL_L  = 0;
  localparam logic [15:0] RC_WMASK = 16'h07FF;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_STAT = 16'h0000;
  localparam logic [15:0] RST_REF  = 16'h0000;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY  = 2'h3;

  localparam logic [1:0] MINUS_PIN_B = 2'h0;
  localparam logic [1:0] MINUS_PIN_C = 2'h1;
  localparam logic [1:0] MINUS_PIN_D = 2'h2;
  localparam logic [1:0] MINUS_REF   = 2'h3;

  localparam logic [1:0] NREF_BG_HALF  = 2'h0;
  localparam logic [1:0] NREF_BG       = 2'h1;
  localparam logic [1:0] NREF_BG_SIXTH = 2'h2;
  localparam logic [1:0] NREF_PIN      = 2'h3;

  // Ladder tap codes: range one gives level/24, range zero 8/32 + level/32
  localparam logic [5:0] LADDER_LO_BASE = 6'h08;

  // Per-unit event detector state
  typedef enum logic [1:0]
  {
    ARMED = 2'b01,
    FIRED = 2'b10
  } evt_state_t;

endpackage

//--- verilog/cmp_unit.sv
// One comparator's control: enable, polarity, sync and event logic.
// Assumes the analog core returns its raw result on analog_raw.
`timescale 1ns/1ps

module cmp_unit
  import cmp_ref_pkg::*;
(
  input  wire logic       sys_clk,       // System clock
  input  wire logic       sys_rst,       // Synchronous reset
  input  wire logic       comparator_on, // Unit enable
  input  wire logic       run_ok,        // Low while halted by idle
  input  wire logic       result_invert, // Output polarity
  input  wire logic [1:0] event_edge_select, // Event edge code
  input  wire logic       event_clear,   // Software clears the flag
  input  wire logic       analog_raw,    // Raw result, plus above minus
  output logic            result_bit,    // Synchronised, polarity applied
  output logic            event_flag,    // Sticky event flag
  output logic            event_pulse,   // One-cycle trigger
  output logic            active         // Analog core enable
);

  // ****************************************************************
  // Synchroniser and event detector
  // ****************************************************************
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  evt_state_t state_r;
  evt_state_t state_nxt;
  logic       rise;
  logic       fall;
  logic       hit;

  assign active     = comparator_on & run_ok;
  assign result_bit = sync2_r;
  assign event_flag = (state_r == FIRED);
  assign rise       = active & sync2_r & ~prev_r;
  assign fall       = active & ~sync2_r & prev_r;
  // Edges seen after polarity, so codes 01/10 swap edge when inverted
  assign hit        = (event_edge_select == EDGE_ANY)  ? (rise | fall) :
                      (event_edge_select == EDGE_RISE) ? rise :
                      (event_edge_select == EDGE_FALL) ? fall : 1'b0;
  assign event_pulse = hit & (state_r == ARMED);

  // Set wins over a clear in the same cycle
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ARMED:   state_nxt = hit ? FIRED : ARMED;
      FIRED:   state_nxt = (event_clear & ~hit) ? ARMED : FIRED;
      default: state_nxt = ARMED;
    endcase
  end

  // Two flops before anything looks at the result
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
      state_r <= ARMED;
    end
    else
    begin
      sync1_r <= (analog_raw ^ result_invert) & active;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      state_r <= state_nxt;
    end
  end

endmodule
